// >>> common/tmr_cfg.svh
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH

// Register indices; the bus byte address of each register is four times its index.
`define TMR_IDX_SC      8'h10
`define TMR_IDX_CNTH    8'h11
`define TMR_IDX_CNTL    8'h12
`define TMR_IDX_MODH    8'h13
`define TMR_IDX_MODL    8'h14
`define TMR_IDX_SHIFT   2

`define TMR_ADDR_W      8
`define TMR_DATA_W      32
`define TMR_BYTE_W      8
`define TMR_CNT_W       16
`define TMR_PS_W        3
`define TMR_DIV_W       7
`define TMR_CLKS_W      2

// Status/control field positions.
`define TMR_BIT_TOF     7
`define TMR_BIT_OVERFLOW_IRQ_ENABLE    6
`define TMR_BIT_CENTER_ALIGN_SELECT   5
`define TMR_BIT_CLKS_HI 4
`define TMR_BIT_CLKS_LO 3
`define TMR_BIT_PS_HI   2
`define TMR_BIT_PS_LO   0

// Counter values.
`define TMR_CNT_ZERO    16'h0000
`define TMR_CNT_ONE     16'h0001
`define TMR_CNT_ONES    16'hFFFF
`define TMR_HI_BYTE     15:8
`define TMR_LO_BYTE     7:0

// Clock source selections.
`define TMR_CLKS_OFF    2'h0
`define TMR_CLKS_BUS    2'h1
`define TMR_CLKS_IDLE   2'h2
`define TMR_CLKS_RF     2'h3

`define TMR_DIV_ZERO    7'h00
`define TMR_DIV_ONE     7'h01
`define TMR_RST_BYTE    8'h00

`endif

// >>> common/tmr_pkg.sv
`include "tmr_cfg.svh"

package tmr_pkg;

   typedef enum logic {
      TMR_DIR_UP,
      TMR_DIR_DOWN
   } tmr_dir_e;

   typedef enum logic [2:0] {
      TMR_REG_NONE,
      TMR_REG_SC,
      TMR_REG_CNTH,
      TMR_REG_CNTL,
      TMR_REG_MODH,
      TMR_REG_MODL
   } tmr_reg_e;

   typedef struct packed {
      logic                    psel;
      logic                    penable;
      logic                    pwrite;
      logic [`TMR_ADDR_W-1:0]  paddr;
      logic [`TMR_DATA_W-1:0]  pwdata;
   } tmr_apb_req_s;

   typedef struct packed {
      logic [`TMR_DATA_W-1:0]  prdata;
      logic                    pready;
      logic                    pslverr;
   } tmr_apb_rsp_s;

   typedef struct packed {
      logic                    sync1;
      logic                    sync2;
      logic                    sync3;
      logic [`TMR_DIV_W-1:0]   div;
      logic                    tick;
   } tmr_tick_s;

   typedef struct packed {
      logic [`TMR_CNT_W-1:0]   cnt;
      tmr_dir_e                dir;
      logic [`TMR_CNT_W-1:0]   modv;
      logic                    mod_hi_pend;
      logic                    mod_lo_pend;
      logic                    tof;
      logic                    tof_armed;
      logic                    overflow_irq_enable;
      logic                    center_align_select;
      logic [`TMR_CLKS_W-1:0]  clks;
      logic [`TMR_PS_W-1:0]    ps;
      logic                    lat_valid;
      logic                    lat_first_hi;
      logic [`TMR_CNT_W-1:0]   lat;
      logic                    tick_out;
      logic                    irq;
      tmr_apb_rsp_s            rsp;
   } tmr_core_s;

endpackage : tmr_pkg

// >>> verilog/tmr_tick.sv
`timescale 1ns/1ps
`include "tmr_cfg.svh"

module tmr_tick (
   input  wire logic                   i_mclk,      // Bus clock.
   input  wire logic                   i_rst,       // Synchronous reset, active high.
   input  wire logic                   i_rf_clk,    // RF-derived clock pin, asynchronous.
   input  wire logic [`TMR_CLKS_W-1:0] i_clks,      // Clock source selection.
   input  wire logic [`TMR_PS_W-1:0]   i_ps,        // Prescale selection.
   output logic                        o_tick       // One-cycle counting pulse.
);

   tmr_pkg::tmr_tick_s st;
   tmr_pkg::tmr_tick_s next_st;
   logic                src_pulse;
   logic [`TMR_DIV_W-1:0] mask;

   always_comb begin
      next_st = st;
      src_pulse = 1'b0;
      // the RF clock passes two flip-flops before the edge detector reads it.
      next_st.sync1 = i_rf_clk;
      next_st.sync2 = st.sync1;
      next_st.sync3 = st.sync2;
      next_st.tick = 1'b0;
      mask = `TMR_DIV_W'((`TMR_DIV_ONE << i_ps) - `TMR_DIV_ONE);
      case (i_clks)
         `TMR_CLKS_BUS: src_pulse = 1'b1;
         `TMR_CLKS_RF:  src_pulse = st.sync2 & ~st.sync3;
         default:       src_pulse = 1'b0;
      endcase
      if (i_clks == `TMR_CLKS_OFF) begin
         next_st.div = `TMR_DIV_ZERO;
      end else if (src_pulse) begin
         if ((st.div & mask) == mask) begin
            next_st.tick = 1'b1;
            next_st.div = `TMR_DIV_ZERO;
         end else begin
            next_st.div = st.div + `TMR_DIV_ONE;
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_tick = st.tick;

endmodule : tmr_tick

// >>> verilog/tmr_core.sv
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "tmr_cfg.svh"

// Function
// - Up mode: set overflow flag when counter rolls from modulo to zero.
// - Center mode: set overflow flag at the step down from the modulo value.
// - Flag clears by reading status with flag set, then writing 0.
// - A new overflow before the clearing write restarts the sequence.
// - Writing 1 to the overflow flag leaves it unchanged.
// - Power-on reset clears the flag; other resets keep it.
// - Interrupt requested while flag and interrupt enable are set and no modulo byte write is pending; reset clears enable.
// - Center-align select 0 counts up; 1 counts up/down for center-aligned PWM.
// - Source 00 off, 01 bus clock, 10 enabled unclocked, 11 RF clock.
// - The RF clock is synchronised to the bus clock before the prescaler.
// - Prescaler after selection divides by two to the power of its field.
// - Reading either counter byte latches both until the other byte is read.
// - Latch re-armed by reset, counter byte write, or status register write.
// - Reset clears the counter to zero.
// - High byte shows counter bits 15:8, low byte bits 7:0.
// - Any write to either counter byte resets the counter.
// - Modulo of all zeros or all ones gives a free-running counter.
// - After one modulo byte write, overflow is suppressed until the other.

module tmr_core (
   input  wire logic                   i_mclk,          // Bus clock, 20 MHz.
   input  wire logic                   i_rst,           // Synchronous MCU reset, active high.
   input  wire logic                   i_por,           // Synchronous power-on reset, active high.
   input  wire logic                   i_rf_clk,        // RF-derived clock pin, asynchronous.
   input  wire tmr_pkg::tmr_apb_req_s  i_apb,           // APB request.
   output tmr_pkg::tmr_apb_rsp_s       o_apb,           // APB response.
   output logic [`TMR_CNT_W-1:0]       o_count,         // Counter value for channels.
   output logic                        o_count_down,    // Counter is counting down.
   output logic                        o_center_align,  // Center-aligned mode for all channels.
   output logic                        o_tick,          // Counter advanced this cycle.
   output logic                        o_irq            // Overflow interrupt request.
);

   localparam tmr_pkg::tmr_core_s CORE_RST = '0;

   tmr_pkg::tmr_core_s    st;
   tmr_pkg::tmr_core_s    next_st;
   tmr_pkg::tmr_reg_e     sel;
   logic                  tick;
   logic                  ovf;
   logic                  acc_new;
   logic                  acc_done;
   logic                  inhibit;
   logic [`TMR_CNT_W-1:0] top;
   logic [`TMR_CNT_W-1:0] rd_val;
   logic [`TMR_BYTE_W-1:0] rd_byte;
   logic [`TMR_BYTE_W-1:0] wr_byte;

   // Maps a byte address onto a register; misaligned or unknown addresses map to none.
   function automatic tmr_pkg::tmr_reg_e decode(input logic [`TMR_ADDR_W-1:0] addr);
      tmr_pkg::tmr_reg_e r;
      r = tmr_pkg::TMR_REG_NONE;
      if (addr == (`TMR_IDX_SC << `TMR_IDX_SHIFT)) begin
         r = tmr_pkg::TMR_REG_SC;
      end else if (addr == (`TMR_IDX_CNTH << `TMR_IDX_SHIFT)) begin
         r = tmr_pkg::TMR_REG_CNTH;
      end else if (addr == (`TMR_IDX_CNTL << `TMR_IDX_SHIFT)) begin
         r = tmr_pkg::TMR_REG_CNTL;
      end else if (addr == (`TMR_IDX_MODH << `TMR_IDX_SHIFT)) begin
         r = tmr_pkg::TMR_REG_MODH;
      end else if (addr == (`TMR_IDX_MODL << `TMR_IDX_SHIFT)) begin
         r = tmr_pkg::TMR_REG_MODL;
      end
      return r;
   endfunction : decode

   // Widens a register byte to the bus width with zeros above.
   function automatic logic [`TMR_DATA_W-1:0] widen(input logic [`TMR_BYTE_W-1:0] b);
      return {{(`TMR_DATA_W-`TMR_BYTE_W){1'b0}}, b};
   endfunction : widen

   tmr_tick u_tick (
      .i_mclk   (i_mclk),
      .i_rst    (i_rst | i_por),
      .i_rf_clk (i_rf_clk),
      .i_clks   (st.clks),
      .i_ps     (st.ps),
      .o_tick   (tick)
   );

   always_comb begin
      next_st  = st;
      ovf      = 1'b0;
      rd_val   = `TMR_CNT_ZERO;
      rd_byte  = `TMR_RST_BYTE;
      wr_byte  = i_apb.pwdata[`TMR_BYTE_W-1:0];
      sel      = decode(i_apb.paddr);
      acc_new  = i_apb.psel & i_apb.penable & ~st.rsp.pready;
      acc_done = i_apb.psel & i_apb.penable & st.rsp.pready;
      inhibit  = st.mod_hi_pend | st.mod_lo_pend;

      // A modulo of zero or all ones lets the counter run through the full range.
      if ((st.modv == `TMR_CNT_ZERO) || (st.modv == `TMR_CNT_ONES)) begin
         top = `TMR_CNT_ONES;
      end else begin
         top = st.modv;
      end

      // Counting, one step per prescaled tick.
      next_st.tick_out = tick;
      if (tick) begin
         if (!st.center_align_select) begin
            next_st.dir = tmr_pkg::TMR_DIR_UP;
            if (st.cnt == top) begin
               next_st.cnt = `TMR_CNT_ZERO;
               ovf = 1'b1;
            end else begin
               next_st.cnt = st.cnt + `TMR_CNT_ONE;
            end
         end else begin
            case (st.dir)
               tmr_pkg::TMR_DIR_UP: begin
                  if (st.cnt >= top) begin
                     next_st.dir = tmr_pkg::TMR_DIR_DOWN;
                     next_st.cnt = st.cnt - `TMR_CNT_ONE;
                     ovf = 1'b1;
                  end else begin
                     next_st.cnt = st.cnt + `TMR_CNT_ONE;
                  end
               end
               tmr_pkg::TMR_DIR_DOWN: begin
                  if (st.cnt == `TMR_CNT_ZERO) begin
                     next_st.dir = tmr_pkg::TMR_DIR_UP;
                     next_st.cnt = `TMR_CNT_ONE;
                  end else begin
                     next_st.cnt = st.cnt - `TMR_CNT_ONE;
                  end
               end
               default: begin
                  next_st.dir = tmr_pkg::TMR_DIR_UP;
               end
            endcase
         end
      end

      // Read phase: data and read side effects are settled when pready is raised.
      next_st.rsp.pready = acc_new;
      if (acc_new) begin
         next_st.rsp.pslverr = (sel == tmr_pkg::TMR_REG_NONE);
         if (!i_apb.pwrite) begin
            case (sel)
               tmr_pkg::TMR_REG_SC: begin
                  rd_byte = {st.tof, st.overflow_irq_enable, st.center_align_select, st.clks, st.ps};
                  if (st.tof) begin
                     next_st.tof_armed = 1'b1;
                  end
               end
               tmr_pkg::TMR_REG_CNTH, tmr_pkg::TMR_REG_CNTL: begin
                  if (st.lat_valid) begin
                     rd_val = st.lat;
                     if ((sel == tmr_pkg::TMR_REG_CNTH) != st.lat_first_hi) begin
                        next_st.lat_valid = 1'b0;
                     end
                  end else begin
                     rd_val = st.cnt;
                     next_st.lat = st.cnt;
                     next_st.lat_valid = 1'b1;
                     next_st.lat_first_hi = (sel == tmr_pkg::TMR_REG_CNTH);
                  end
                  if (sel == tmr_pkg::TMR_REG_CNTH) begin
                     rd_byte = rd_val[`TMR_HI_BYTE];
                  end else begin
                     rd_byte = rd_val[`TMR_LO_BYTE];
                  end
               end
               tmr_pkg::TMR_REG_MODH: rd_byte = st.modv[`TMR_HI_BYTE];
               tmr_pkg::TMR_REG_MODL: rd_byte = st.modv[`TMR_LO_BYTE];
               default: rd_byte = `TMR_RST_BYTE;
            endcase
         end
         next_st.rsp.prdata = widen(rd_byte);
      end

      // Write phase: takes effect at the edge where the master sees pready high.
      if (acc_done && i_apb.pwrite) begin
         case (sel)
            tmr_pkg::TMR_REG_SC: begin
               next_st.overflow_irq_enable  = wr_byte[`TMR_BIT_OVERFLOW_IRQ_ENABLE];
               next_st.center_align_select = wr_byte[`TMR_BIT_CENTER_ALIGN_SELECT];
               next_st.clks  = wr_byte[`TMR_BIT_CLKS_HI:`TMR_BIT_CLKS_LO];
               next_st.ps    = wr_byte[`TMR_BIT_PS_HI:`TMR_BIT_PS_LO];
               next_st.lat_valid = 1'b0;
               if (!wr_byte[`TMR_BIT_TOF] && st.tof_armed) begin
                  next_st.tof = 1'b0;
                  next_st.tof_armed = 1'b0;
               end
            end
            tmr_pkg::TMR_REG_CNTH, tmr_pkg::TMR_REG_CNTL: begin
               next_st.cnt = `TMR_CNT_ZERO;
               next_st.dir = tmr_pkg::TMR_DIR_UP;
               next_st.lat_valid = 1'b0;
            end
            tmr_pkg::TMR_REG_MODH: begin
               next_st.modv[`TMR_HI_BYTE] = wr_byte;
               next_st.mod_hi_pend = ~st.mod_lo_pend;
               next_st.mod_lo_pend = 1'b0;
            end
            tmr_pkg::TMR_REG_MODL: begin
               next_st.modv[`TMR_LO_BYTE] = wr_byte;
               next_st.mod_lo_pend = ~st.mod_hi_pend;
               next_st.mod_hi_pend = 1'b0;
            end
            default: begin
               next_st.tof = st.tof;
            end
         endcase
      end

      // The overflow is applied last so that it wins over a clearing write in the same cycle.
      if (ovf && !inhibit) begin
         next_st.tof = 1'b1;
         next_st.tof_armed = 1'b0;
      end

      next_st.irq = next_st.tof & next_st.overflow_irq_enable & ~(next_st.mod_hi_pend | next_st.mod_lo_pend);

      // An MCU reset restores every field but keeps the overflow flag.
      if (i_rst) begin
         next_st = CORE_RST;
         next_st.tof = st.tof;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_por) begin
         st <= CORE_RST;
      end else begin
         st <= next_st;
      end
   end

   assign o_apb          = st.rsp;
   assign o_count        = st.cnt;
   assign o_count_down   = (st.dir == tmr_pkg::TMR_DIR_DOWN);
   assign o_center_align = st.center_align_select;
   assign o_tick         = st.tick_out;
   assign o_irq          = st.irq;

endmodule : tmr_core

// >>> testbench/tmr_core_assertions.sv
`timescale 1ns/1ps
`include "tmr_cfg.svh"

module tmr_core_checker (
   input wire logic                  i_mclk,         // Bus clock.
   input wire logic                  i_rst,          // MCU reset.
   input wire logic                  i_por,          // Power-on reset.
   input wire logic                  i_rf_clk,       // RF clock pin.
   input wire tmr_pkg::tmr_apb_req_s i_apb,          // APB request.
   input wire tmr_pkg::tmr_apb_rsp_s o_apb,          // APB response.
   input wire logic [`TMR_CNT_W-1:0] o_count,        // Counter value.
   input wire logic                  o_count_down,   // Counting down.
   input wire logic                  o_center_align, // Center mode.
   input wire logic                  o_tick,         // Counter step.
   input wire logic                  o_irq           // Overflow request.
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst || i_por);

   a_ready_wait: assert property (i_apb.psel && i_apb.penable && !o_apb.pready |=> o_apb.pready)
      else $error("pready late");
   a_ready_pulse: assert property (o_apb.pready |=> !o_apb.pready)
      else $error("pready too long");
   a_count_clear: assert property ($past(i_rst || i_por) |-> o_count == `TMR_CNT_ZERO)
      else $error("count not cleared");
   a_irq_clear: assert property ($past(i_rst || i_por) |-> !o_irq)
      else $error("irq after reset");
   a_align_clear: assert property ($past(i_rst || i_por) |-> !o_center_align)
      else $error("center mode after reset");
   a_up_step: assert property (!o_center_align && !$past(o_center_align) && !$past(i_rst || i_por)
      && o_count != $past(o_count) |-> o_count == 16'($past(o_count) + 16'h0001) || o_count == 16'h0000)
      else $error("bad up step");
   a_center_step: assert property (o_center_align && $past(o_center_align) && !$past(i_rst || i_por)
      && o_count != $past(o_count) |-> o_count == 16'($past(o_count) + 16'h0001)
      || o_count == 16'($past(o_count) - 16'h0001) || o_count == 16'h0000)
      else $error("bad center step");
   a_down_center: assert property ($rose(o_count_down) |-> o_center_align)
      else $error("down count in up mode");
   a_irq_cause: assert property ($rose(o_irq) |-> o_tick || $past(o_tick) || $past(o_tick, 2)
      || $past(o_apb.pready) || $past(o_apb.pready, 2))
      else $error("irq without cause");
endmodule : tmr_core_checker

bind tmr_core tmr_core_checker chk_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_por(i_por), .i_rf_clk(i_rf_clk),
   .i_apb(i_apb), .o_apb(o_apb), .o_count(o_count), .o_count_down(o_count_down),
   .o_center_align(o_center_align), .o_tick(o_tick), .o_irq(o_irq));

// >>> testbench/tb.sv
`timescale 1ns/1ps
`include "tmr_cfg.svh"

module tb;
   localparam logic [7:0] A_SC = 8'h40, A_CH = 8'h44, A_CL = 8'h48, A_MH = 8'h4C, A_ML = 8'h50;
   logic                  i_mclk, i_rst, i_por, i_rf_clk, down, align, tick, irq, err, dn;
   tmr_pkg::tmr_apb_req_s req;
   tmr_pkg::tmr_apb_rsp_s rsp;
   logic [15:0]           cnt, a1, b1, mx;
   logic [31:0]           rd;
   logic [1:0]            src;
   logic [2:0]            ps;
   int                    fail_count, num_checks, rf_div, expc, nt;

   tmr_core uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_por(i_por), .i_rf_clk(i_rf_clk), .i_apb(req),
      .o_apb(rsp), .o_count(cnt), .o_count_down(down), .o_center_align(align), .o_tick(tick), .o_irq(irq));

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic near(input string name, input int exp, input logic [15:0] got);
      chk(name, 32'h1, {31'h0, (int'(got) <= exp + 2) && (int'(got) + 2 >= exp) && !$isunknown(got)});
   endtask : near

   // Waits for pready without a limit of its own; the watchdog ends a hung transfer.
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge i_mclk);
      req.penable <= 1'b1;
      do begin
         @(posedge i_mclk);
      end while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req <= '0;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer(1'b1, a, {24'h0, d});
   endtask : wr

   task automatic rdc(input logic [7:0] a, input string name, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(name, exp, rd);
   endtask : rdc

   task automatic watch(input int n);
      mx = 16'h0;
      dn = 1'b0;
      nt = 0;
      repeat (n) begin
         @(posedge i_mclk);
         if (cnt > mx) mx = cnt;
         if (down === 1'b1) dn = 1'b1;
         if (tick === 1'b1) nt++;
      end
   endtask : watch

   task automatic tally_and_finish;
      if (fail_count == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : tally_and_finish

   initial begin
      i_mclk = 1'b0;
      forever #25 i_mclk = ~i_mclk;
   end

   // The RF-derived clock toggles every 20 bus cycles, a 500 kHz square wave.
   always @(posedge i_mclk) begin
      if (i_por) begin
         rf_div   <= 0;
         i_rf_clk <= 1'b0;
      end else begin
         rf_div <= (rf_div == 19) ? 0 : rf_div + 1;
         if (rf_div == 19) i_rf_clk <= ~i_rf_clk;
      end
   end

   initial begin
      repeat (60000) @(posedge i_mclk);
      fail_count++;
      tally_and_finish();
   end

   initial begin
      i_rst = 1'b1;
      i_por = 1'b1;
      req = '0;
      repeat (12) @(posedge i_mclk);
      i_rst <= 1'b0;
      i_por <= 1'b0;
      rdc(A_SC, "status", 32'h0);
      rdc(A_CH, "cnt_hi", 32'h0);
      rdc(A_CL, "cnt_lo", 32'h0);
      xfer(1'b0, 8'h54, 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
      wr(A_SC, 8'h08);
      xfer(1'b0, A_CH, 32'h0);
      a1[15:8] = rd[7:0];
      repeat (300) @(posedge i_mclk);
      xfer(1'b0, A_CL, 32'h0);
      a1[7:0] = rd[7:0];
      xfer(1'b0, A_CL, 32'h0);
      b1[7:0] = rd[7:0];
      repeat (300) @(posedge i_mclk);
      xfer(1'b0, A_CH, 32'h0);
      b1[15:8] = rd[7:0];
      chk("coherent", {16'h0, 16'(a1 + 16'd308)}, {16'h0, b1});
      xfer(1'b0, A_CH, 32'h0);
      wr(A_CL, 8'h5A);
      xfer(1'b0, A_CL, 32'h0);
      chk("cnt_lo_fresh", 32'h1, {31'h0, rd < 32'h8});
      rdc(A_CH, "cnt_hi_fresh", 32'h0);
      wr(A_CH, 8'h00);
      wr(A_ML, 8'h20);
      repeat (200) @(posedge i_mclk);
      rdc(A_SC, "tof_inhibit", 32'h08);
      wr(A_MH, 8'h00);
      wr(A_CL, 8'h00);
      watch(100);
      chk("mod_top", 32'h20, {16'h0, mx});
      chk("tick_rate", 32'd100, nt);
      wr(A_SC, 8'hD0);
      repeat (3) @(posedge i_mclk);
      chk("irq_on", 32'h1, {31'h0, irq});
      wr(A_SC, 8'h50);
      rdc(A_SC, "tof_kept", 32'hD0);
      wr(A_SC, 8'hD0);
      rdc(A_SC, "tof_one", 32'hD0);
      wr(A_SC, 8'hC8);
      repeat (100) @(posedge i_mclk);
      wr(A_SC, 8'h50);
      rdc(A_SC, "tof_rearm", 32'hD0);
      wr(A_SC, 8'h50);
      rdc(A_SC, "tof_clear", 32'h50);
      repeat (3) @(posedge i_mclk);
      chk("irq_off", 32'h0, {31'h0, irq});
      wr(A_SC, 8'h08);
      repeat (100) @(posedge i_mclk);
      wr(A_SC, 8'h10);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_mclk);
      i_rst <= 1'b0;
      rdc(A_SC, "tof_soft_rst", 32'h80);
      chk("cnt_rst", 32'h0, {16'h0, cnt});
      i_por <= 1'b1;
      repeat (2) @(posedge i_mclk);
      i_por <= 1'b0;
      rdc(A_SC, "tof_por", 32'h0);
      for (int k = 0; k < 11; k++) begin
         src = (k < 8) ? 2'h1 : (k == 8) ? 2'h0 : (k == 9) ? 2'h2 : 2'h3;
         ps = (k < 8) ? 3'(k) : 3'h0;
         wr(A_SC, {3'h0, 2'h2, ps});
         wr(A_CH, 8'h00);
         wr(A_SC, {3'h0, src, ps});
         repeat (800) @(posedge i_mclk);
         wr(A_SC, {3'h0, 2'h2, ps});
         expc = (src == 2'h1) ? (804 >> ps) : (src == 2'h3) ? 804 / 40 : 0;
         near("count_rate", expc, cnt);
      end
      wr(A_ML, 8'h10);
      wr(A_MH, 8'h00);
      wr(A_CH, 8'h00);
      wr(A_SC, 8'h28);
      watch(100);
      chk("align", 32'h1, {31'h0, align});
      chk("center_top", 32'h10, {16'h0, mx});
      chk("center_down", 32'h1, {31'h0, dn});
      rdc(A_ML, "mod_lo", 32'h10);
      rdc(A_MH, "mod_hi", 32'h0);
      rdc(A_SC, "tof_center", 32'hA8);
      tally_and_finish();
   end
endmodule : tb
